/* File: gpt_timer.sv */
// General-purpose 16-bit up/down timer with AXI4-Lite register access
`include "gpt_map.svh"
module gpt_timer (
    // Clock, reset, clock enable
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic        clk_en_in,
    // AXI4-Lite write address and data
    input  wire logic [31:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // AXI4-Lite read
    input  wire logic [31:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Timer clock sources, synchronous levels
    input  wire logic        core_clk_in,
    input  wire logic        slow_osc_32k_in,
    input  wire logic        fast_crystal_osc_in,
    input  wire logic        fast_internal_osc_in,
    input  wire logic        clock_config0_xtal_in,
    // Capture event sources
    input  wire logic [15:0] capture_events_in,
    // Timeout interrupt
    output logic             timeout_irq_out
);
    import gpt_pkg::*;

    gpt_core_if core ();

    // Register state
    gpt_word_t   load_value_r;
    gpt_word_t   load_pend_val_r;
    logic        load_pend_r;
    logic [12:0] ctrl_r;
    gpt_word_t   cnt_r;
    gpt_word_t   val1_r;
    gpt_word_t   val2_r;
    logic        sta_tmo_r;
    gpt_state_t  state_r;
    gpt_state_t  state_nxt;

    // Bus state
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;

    // Decoded write strobes
    logic        wr_go;
    logic        wr_load;
    logic        wr_ctrl;
    logic        wr_clear;
    logic        wr_hit;
    logic [15:0] wr_mask;
    logic [15:0] ctrl_new;
    logic        clr_tmo;
    logic        clr_cap;

    // Counter terms
    logic        en;
    logic        periodic;
    logic        up;
    logic        reload_on_clear;
    gpt_word_t   step;
    gpt_word_t   terminal;
    logic        tmo_now;
    logic        clr_reload;

    assign en       = ctrl_r[`GPT_CB_EN];
    assign periodic = ctrl_r[`GPT_CB_MODE];
    assign up       = ctrl_r[`GPT_CB_UP];
    assign reload_on_clear      = ctrl_r[`GPT_CB_RLD];

    // Write side: address and data taken in either order, then one response
    assign wr_go    = !awready_r && !wready_r && !bvalid_r;
    assign wr_mask  = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wr_load  = wr_go && awaddr_r == `GPT_ADDR_LOAD;
    assign wr_ctrl  = wr_go && awaddr_r == `GPT_ADDR_CTRL;
    assign wr_clear = wr_go && awaddr_r == `GPT_ADDR_CLEAR && wstrb_r[0];
    assign wr_hit   = awaddr_r == `GPT_ADDR_LOAD || awaddr_r == `GPT_ADDR_CTRL
                   || awaddr_r == `GPT_ADDR_CLEAR;
    assign ctrl_new = ({3'b000, ctrl_r} & ~wr_mask) | (wdata_r[15:0] & wr_mask);
    assign clr_tmo  = wr_clear && wdata_r[`GPT_CLR_TMO];
    assign clr_cap  = wr_clear && wdata_r[`GPT_CLR_CAP];

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            awready_r <= 1'b1;
            awaddr_r  <= 32'h0000_0000;
        end else if (clk_en_in) begin
            if (s_axi_awvalid_in && awready_r) begin
                awready_r <= 1'b0;
                awaddr_r  <= s_axi_awaddr_in;
            end else if (bvalid_r && s_axi_bready_in) begin
                awready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            wready_r <= 1'b1;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else if (clk_en_in) begin
            if (s_axi_wvalid_in && wready_r) begin
                wready_r <= 1'b0;
                wdata_r  <= s_axi_wdata_in;
                wstrb_r  <= s_axi_wstrb_in;
            end else if (bvalid_r && s_axi_bready_in) begin
                wready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `GPT_RESP_OKAY;
        end else if (clk_en_in) begin
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read side: data one cycle after the address is taken
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= `GPT_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else if (clk_en_in) begin
            if (s_axi_arvalid_in && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rresp_r   <= `GPT_RESP_OKAY;
                case (s_axi_araddr_in)
                    `GPT_ADDR_LOAD:  rdata_r <= {16'h0000, load_value_r};
                    `GPT_ADDR_VALUE: rdata_r <= {16'h0000, val2_r};
                    `GPT_ADDR_CTRL:  rdata_r <= {19'h0_0000, ctrl_r};
                    `GPT_ADDR_CAPT:  rdata_r <= {16'h0000, core.cap_val};
                    `GPT_ADDR_STAT:  rdata_r <= {30'h0000_0000, core.cap_pend, sta_tmo_r};
                    `GPT_ADDR_CLEAR: rdata_r <= 32'h0000_0000;
                    default: begin
                        rdata_r <= 32'h0000_0000;
                        rresp_r <= `GPT_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_r && s_axi_rready_in) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // Control register
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_r <= 13'(`GPT_CTRL_RESET);
        end else if (clk_en_in && wr_ctrl) begin
            ctrl_r <= ctrl_new[12:0];
        end
    end

    // Load value, deferred past a timeout to avoid a torn reload
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            load_value_r    <= `GPT_LOAD_RESET;
            load_pend_val_r <= `GPT_LOAD_RESET;
            load_pend_r     <= 1'b0;
        end else if (clk_en_in) begin
            if (wr_load && tmo_now) begin
                load_pend_val_r <= (load_value_r & ~wr_mask) | (wdata_r[15:0] & wr_mask);
                load_pend_r     <= 1'b1;
            end else if (wr_load) begin
                load_value_r <= (load_value_r & ~wr_mask) | (wdata_r[15:0] & wr_mask);
                load_pend_r  <= 1'b0;
            end else if (load_pend_r && !tmo_now) begin
                load_value_r <= load_pend_val_r;
                load_pend_r  <= 1'b0;
            end
        end
    end

    // Counter sequencing
    always_comb begin
        case (state_r)
            GPT_ST_IDLE:  state_nxt = en ? GPT_ST_START : GPT_ST_IDLE;
            GPT_ST_START: state_nxt = en ? GPT_ST_RUN : GPT_ST_IDLE;
            GPT_ST_RUN:   state_nxt = en ? GPT_ST_RUN : GPT_ST_IDLE;
            default:      state_nxt = GPT_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= GPT_ST_IDLE;
        end else if (clk_en_in) begin
            state_r <= state_nxt;
        end
    end

    assign step       = up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
    assign terminal   = up ? `GPT_FULL_SCALE : `GPT_ZERO_SCALE;
    assign tmo_now    = state_r == GPT_ST_RUN && core.tick && step == terminal;
    assign clr_reload = state_r == GPT_ST_RUN && periodic && reload_on_clear && clr_tmo;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_r <= `GPT_ZERO_SCALE;
        end else if (clk_en_in) begin
            if (!en || state_r == GPT_ST_IDLE) begin
                cnt_r <= `GPT_ZERO_SCALE;
            end else if (state_r == GPT_ST_START) begin
                cnt_r <= periodic ? load_value_r : (up ? `GPT_ZERO_SCALE : `GPT_FULL_SCALE);
            end else if (clr_reload || (tmo_now && periodic)) begin
                cnt_r <= load_value_r;
            end else if (core.tick) begin
                cnt_r <= step;
            end
        end
    end

    // Two-stage view of the count for reads
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            val1_r <= `GPT_ZERO_SCALE;
            val2_r <= `GPT_ZERO_SCALE;
        end else if (clk_en_in) begin
            val1_r <= cnt_r;
            val2_r <= val1_r;
        end
    end

    // Timeout status; a new timeout beats a simultaneous clear
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            sta_tmo_r <= 1'b0;
        end else if (clk_en_in) begin
            if (tmo_now) begin
                sta_tmo_r <= 1'b1;
            end else if (clr_tmo) begin
                sta_tmo_r <= 1'b0;
            end
        end
    end

    // Sub-block wiring
    assign core.src_sel  = gpt_src_t'(ctrl_r[`GPT_CB_CLK_HI:`GPT_CB_CLK_LO]);
    assign core.pre_sel  = ctrl_r[`GPT_CB_PRE_HI:`GPT_CB_PRE_LO];
    assign core.xtal_sel = clock_config0_xtal_in;
    // Drops with enable, so no stray tick follows a stop
    assign core.run      = state_r == GPT_ST_RUN && en;
    assign core.src_lvl  = {fast_internal_osc_in, fast_crystal_osc_in,
                            slow_osc_32k_in, core_clk_in};
    assign core.cap_en   = ctrl_r[`GPT_CB_CAPEN];
    assign core.cap_sel  = ctrl_r[`GPT_CB_EVT_HI:`GPT_CB_EVT_LO];
    assign core.events   = capture_events_in;
    assign core.count    = cnt_r;
    assign core.cap_clr  = clr_cap;

    gpt_prescaler u_presc (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .clk_en_in  (clk_en_in),
        .core       (core.presc)
    );

    gpt_capture u_capt (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .clk_en_in  (clk_en_in),
        .cap        (core.capt)
    );

    assign s_axi_awready_out = awready_r;
    assign s_axi_wready_out  = wready_r;
    assign s_axi_bvalid_out  = bvalid_r;
    assign s_axi_bresp_out   = bresp_r;
    assign s_axi_arready_out = arready_r;
    assign s_axi_rvalid_out  = rvalid_r;
    assign s_axi_rresp_out   = rresp_r;
    assign s_axi_rdata_out   = rdata_r;
    assign timeout_irq_out   = sta_tmo_r;

    // Checks
    sequence s_run_tick;
        clk_en_in && state_r == GPT_ST_RUN && core.tick;
    endsequence

    sequence s_start_free;
        clk_en_in && state_r == GPT_ST_START && !periodic;
    endsequence

    a_val_lag: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        ($past(clk_en_in, 1) && $past(clk_en_in, 2)) |-> val2_r == $past(cnt_r, 2))
        else $error("counter value view does not lag by two cycles");

    a_disable_zero: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && !en) |=> cnt_r == `GPT_ZERO_SCALE && !core.tick)
        else $error("counter not zeroed while disabled");

    a_load_defer: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && wr_load && tmo_now) |=> $stable(load_value_r) && load_pend_r)
        else $error("load written during timeout");

    a_tmo_flag: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (s_run_tick and tmo_now) |=> sta_tmo_r && timeout_irq_out)
        else $error("timeout not flagged");

    a_free_start: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        s_start_free |=> cnt_r == ($past(up) ? `GPT_ZERO_SCALE : `GPT_FULL_SCALE))
        else $error("free running start value wrong");

    a_periodic_rld: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (s_run_tick and tmo_now && periodic) |=> cnt_r == $past(load_value_r))
        else $error("periodic timeout did not reload");

    a_step_one: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (s_run_tick and !tmo_now && !clr_reload && en)
        |=> cnt_r == ($past(up) ? $past(cnt_r) + 16'h0001 : $past(cnt_r) - 16'h0001))
        else $error("counter step wrong");

    a_clr_reload: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && clr_reload && en) |=> cnt_r == $past(load_value_r))
        else $error("clear did not reload counter");

    a_hold_idle: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && state_r == GPT_ST_RUN && en && !core.tick && !clr_reload)
        |=> $stable(cnt_r))
        else $error("counter moved without a tick");

    a_wr_resp: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && wr_go) |=> s_axi_bvalid_out)
        else $error("write response missing");
endmodule

/* File: gpt_map.svh */
// Register addresses, field positions, reset values and divider limits of the timer
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

`define GPT_ADDR_LOAD    32'h4000_0000
`define GPT_ADDR_VALUE   32'h4000_0004
`define GPT_ADDR_CTRL    32'h4000_0008
`define GPT_ADDR_CLEAR   32'h4000_000C
`define GPT_ADDR_CAPT    32'h4000_0010
`define GPT_ADDR_STAT    32'h4000_001C

`define GPT_CTRL_RESET   16'h000A
`define GPT_LOAD_RESET   16'h0000
`define GPT_FULL_SCALE   16'hFFFF
`define GPT_ZERO_SCALE   16'h0000

`define GPT_CB_CAPEN     12
`define GPT_CB_EVT_HI    11
`define GPT_CB_EVT_LO    8
`define GPT_CB_RLD       7
`define GPT_CB_CLK_HI    6
`define GPT_CB_CLK_LO    5
`define GPT_CB_EN        4
`define GPT_CB_MODE      3
`define GPT_CB_UP        2
`define GPT_CB_PRE_HI    1
`define GPT_CB_PRE_LO    0

`define GPT_CLR_TMO      0
`define GPT_CLR_CAP      1
`define GPT_SB_TMO       0
`define GPT_SB_CAP       1

`define GPT_DIV1_LIM     15'h0000
`define GPT_DIV4_LIM     15'h0003
`define GPT_DIV16_LIM    15'h000F
`define GPT_DIV256_LIM   15'h00FF
`define GPT_DIV32K_LIM   15'h7FFF

`define GPT_RESP_OKAY    2'b00
`define GPT_RESP_SLVERR  2'b10

`endif

/* File: gpt_pkg.sv */
// Types shared by the timer modules
package gpt_pkg;
    typedef enum logic [1:0] {
        GPT_SRC_BUS  = 2'b00,
        GPT_SRC_CORE = 2'b01,
        GPT_SRC_SLOW = 2'b10,
        GPT_SRC_FAST = 2'b11
    } gpt_src_t;
    typedef enum logic [1:0] {
        GPT_ST_IDLE  = 2'b00,
        GPT_ST_START = 2'b01,
        GPT_ST_RUN   = 2'b10
    } gpt_state_t;
    typedef logic [15:0] gpt_word_t;
endpackage

/* File: gpt_core_if.sv */
// Signals between the timer core, its prescaler and its capture unit
interface gpt_core_if;
    import gpt_pkg::*;
    gpt_src_t   src_sel;
    logic [1:0] pre_sel;
    logic       xtal_sel;
    logic       run;
    logic [3:0] src_lvl;
    logic       tick;
    logic       cap_en;
    logic [3:0] cap_sel;
    logic [15:0] events;
    gpt_word_t  count;
    logic       cap_clr;
    gpt_word_t  cap_val;
    logic       cap_pend;
    modport ctrl  (output src_sel, pre_sel, xtal_sel, run, src_lvl, cap_en, cap_sel, events,
                   count, cap_clr, input tick, cap_val, cap_pend);
    modport presc (input src_sel, pre_sel, xtal_sel, run, src_lvl, output tick);
    modport capt  (input cap_en, cap_sel, events, count, cap_clr, output cap_val, cap_pend);
endinterface

/* File: gpt_prescaler.sv */
// Clock source selection and prescaler producing one count tick per division
`include "gpt_map.svh"
module gpt_prescaler (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic reset_in,
    input  wire logic clk_en_in,
    // Core side
    gpt_core_if.presc core
);
    import gpt_pkg::*;

    logic [3:0]  lvl_r;
    logic [14:0] div_r;
    logic        tick_r;
    logic        src_tick;
    logic [14:0] lim;

    always_comb begin
        case (core.src_sel)
            GPT_SRC_BUS:  src_tick = 1'b1;
            GPT_SRC_CORE: src_tick = core.src_lvl[0] & ~lvl_r[0];
            GPT_SRC_SLOW: src_tick = core.src_lvl[1] & ~lvl_r[1];
            GPT_SRC_FAST: src_tick = core.xtal_sel ? (core.src_lvl[2] & ~lvl_r[2])
                                                   : (core.src_lvl[3] & ~lvl_r[3]);
            default:      src_tick = 1'b0;
        endcase
        case (core.pre_sel)
            2'b00:   lim = (core.src_sel == GPT_SRC_BUS || core.src_sel == GPT_SRC_CORE)
                           ? `GPT_DIV4_LIM : `GPT_DIV1_LIM;
            2'b01:   lim = `GPT_DIV16_LIM;
            2'b10:   lim = `GPT_DIV256_LIM;
            default: lim = `GPT_DIV32K_LIM;
        endcase
    end

    // Sources are plain synchronous levels; rising edges count
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            lvl_r <= 4'h0;
        end else if (clk_en_in) begin
            lvl_r <= core.src_lvl;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            div_r  <= 15'h0000;
            tick_r <= 1'b0;
        end else if (clk_en_in) begin
            if (!core.run) begin
                div_r  <= 15'h0000;
                tick_r <= 1'b0;
            end else if (src_tick) begin
                // Limit may shrink under a running divider, hence >=
                tick_r <= (div_r >= lim);
                div_r  <= (div_r >= lim) ? 15'h0000 : div_r + 15'h0001;
            end else begin
                tick_r <= 1'b0;
            end
        end
    end

    assign core.tick = tick_r;

    a_pre_idle: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && !core.run) |=> !core.tick)
        else $error("prescaler ticked while timer stopped");
endmodule

/* File: gpt_capture.sv */
// Event capture: latches the count on the first edge of the selected event
`include "gpt_map.svh"
module gpt_capture (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic reset_in,
    input  wire logic clk_en_in,
    // Core side
    gpt_core_if.capt cap
);
    import gpt_pkg::*;

    logic [15:0] evt_r;
    gpt_word_t   val_r;
    logic        pend_r;
    logic        hit;

    // Initial assertion of the selected source only
    assign hit = cap.cap_en && cap.events[cap.cap_sel] && !evt_r[cap.cap_sel];

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            evt_r <= 16'h0000;
        end else if (clk_en_in) begin
            evt_r <= cap.events;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            val_r  <= 16'h0000;
            pend_r <= 1'b0;
        end else if (clk_en_in) begin
            if (hit && (!pend_r || cap.cap_clr)) begin
                val_r  <= cap.count;
                pend_r <= 1'b1;
            end else if (cap.cap_clr) begin
                pend_r <= 1'b0;
            end
        end
    end

    assign cap.cap_val  = val_r;
    assign cap.cap_pend = pend_r;

    a_cap_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && pend_r && !cap.cap_clr) |=> ($stable(val_r) && pend_r))
        else $error("captured value changed while pending");
endmodule

/* File: gpt_timer_tb.sv */
// Self-checking bench for the general purpose timer
`include "gpt_map.svh"
module gpt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_in = 0, reset_in = 1, clk_en_in = 1;
    logic [31:0] s_axi_awaddr_in = 0, s_axi_wdata_in = 0, s_axi_araddr_in = 0;
    logic [3:0]  s_axi_wstrb_in = 0;
    logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic        s_axi_arvalid_in = 0, s_axi_rready_in = 0;
    logic        core_clk_in = 0, slow_osc_32k_in = 0, fast_crystal_osc_in = 0;
    logic        fast_internal_osc_in = 0, clock_config0_xtal_in = 0;
    logic [15:0] capture_events_in = 0;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic        s_axi_arready_out, s_axi_rvalid_out, timeout_irq_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out;
    int          fail_count = 0, n_tests = 0;

    gpt_timer dut_u (.clk_sys_in, .reset_in, .clk_en_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
        .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
        .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
        .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .core_clk_in,
        .slow_osc_32k_in, .fast_crystal_osc_in, .fast_internal_osc_in,
        .clock_config0_xtal_in, .capture_events_in, .timeout_irq_out);

    always #5 clk_sys_in = ~clk_sys_in;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    // Holds each channel until its own ready; bready stays up until bvalid
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= 4'hF;
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        s_axi_bready_in <= 1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 0;
        end while (s_axi_bvalid_out !== 1'b1 && ++k < 50);
        s_axi_bready_in <= 0;
        chk("bvalid", 32'h1, {31'h0, s_axi_bvalid_out});
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_out});
    endtask

    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk_sys_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        s_axi_rready_in <= 1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 0;
        end while (s_axi_rvalid_out !== 1'b1 && ++k < 50);
        s_axi_rready_in <= 0;
        chk("rvalid", 32'h1, {31'h0, s_axi_rvalid_out});
        chk(nm, e, s_axi_rdata_out);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_out});
    endtask

    // n rising edges of the slow source per call
    task automatic slow_edges(input int n);
        repeat (n) begin
            @(posedge clk_sys_in) slow_osc_32k_in <= 1;
            @(posedge clk_sys_in) slow_osc_32k_in <= 0;
        end
        repeat (4) @(posedge clk_sys_in);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fail_count++;
        stop_test;
    end

    initial begin
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 0;
        rd("control", `GPT_ADDR_CTRL, 32'h0000_000A, 2'b00);
        rd("load", `GPT_ADDR_LOAD, 32'h0000_0000, 2'b00);
        rd("value", `GPT_ADDR_VALUE, 32'h0000_0000, 2'b00);
        rd("status", `GPT_ADDR_STAT, 32'h0000_0000, 2'b00);
        rd("unmapped", 32'h4000_0020, 32'h0000_0000, 2'b10);
        wr(`GPT_ADDR_VALUE, 32'h0000_1234, 2'b10);
        wr(`GPT_ADDR_LOAD, 32'h0000_1234, 2'b00);
        rd("load", `GPT_ADDR_LOAD, 32'h0000_1234, 2'b00);
        $display("test registers done");
        // Long period so the clear is not raced by a second timeout
        wr(`GPT_ADDR_LOAD, 32'h0000_00FF, 2'b00);
        wr(`GPT_ADDR_CTRL, 32'h0000_0018, 2'b00);
        repeat (1100) @(posedge clk_sys_in);
        rd("status", `GPT_ADDR_STAT, 32'h0000_0001, 2'b00);
        chk("irq", 32'h1, {31'h0, timeout_irq_out});
        wr(`GPT_ADDR_CLEAR, 32'h0000_0001, 2'b00);
        rd("status", `GPT_ADDR_STAT, 32'h0000_0000, 2'b00);
        wr(`GPT_ADDR_CTRL, 32'h0000_0008, 2'b00);
        repeat (4) @(posedge clk_sys_in);
        rd("value", `GPT_ADDR_VALUE, 32'h0000_0000, 2'b00);
        $display("test periodic done");
        // Reload on clear, bus clock divided by 256
        wr(`GPT_ADDR_LOAD, 32'h0000_0010, 2'b00);
        wr(`GPT_ADDR_CTRL, 32'h0000_009A, 2'b00);
        repeat (600) @(posedge clk_sys_in);
        wr(`GPT_ADDR_CLEAR, 32'h0000_0001, 2'b00);
        rd("value", `GPT_ADDR_VALUE, 32'h0000_0010, 2'b00);
        wr(`GPT_ADDR_CTRL, 32'h0000_0008, 2'b00);
        $display("test reload on clear done");
        // Free running up on slow source, undivided, capture on event 3
        wr(`GPT_ADDR_CTRL, 32'h0000_1354, 2'b00);
        repeat (4) @(posedge clk_sys_in);
        slow_edges(5);
        rd("value", `GPT_ADDR_VALUE, 32'h0000_0005, 2'b00);
        @(posedge clk_sys_in) capture_events_in <= 16'h0008;
        rd("capture", `GPT_ADDR_CAPT, 32'h0000_0005, 2'b00);
        rd("status", `GPT_ADDR_STAT, 32'h0000_0002, 2'b00);
        @(posedge clk_sys_in) capture_events_in <= 16'h0000;
        slow_edges(1);
        @(posedge clk_sys_in) capture_events_in <= 16'h0008;
        rd("capture", `GPT_ADDR_CAPT, 32'h0000_0005, 2'b00);
        wr(`GPT_ADDR_CLEAR, 32'h0000_0002, 2'b00);
        rd("status", `GPT_ADDR_STAT, 32'h0000_0000, 2'b00);
        $display("test free capture done");
        stop_test;
    end
endmodule
